// ===== hw/cdid_decoder.v
`include "cdid_defines.vh"
`default_nettype none
module cdid_decoder #(
  parameter BLINK_HALF = `CDID_BLINK_HALF
) (
  input  wire       clk_sys_i,
  input  wire       rst_b_i,
  input  wire       xfer_strobe_i,
  input  wire       register_select_i,
  input  wire       read_not_write_i,
  input  wire [7:0] data_i,
  output reg  [7:0] data_o,
  output reg        read_valid_o,
  output reg  [6:0] address_counter_o,
  output reg        glyph_select_o,
  output reg        increment_direction_o,
  output reg        shift_enable_o,
  output reg        display_enable_o,
  output reg        cursor_enable_o,
  output reg        blink_enable_o,
  output reg        blink_phase_o,
  output reg        bus_width_select_o,
  output reg        two_lines_o,
  output reg        luminance_code_high_o,
  output reg        luminance_code_low_o,
  output reg  [6:0] display_shift_o,
  output reg        clear_busy_o
);
  reg  [7:0]  dd_mem [0:`CDID_DD_DEPTH-1];
  reg  [7:0]  cg_mem [0:`CDID_CG_DEPTH-1];
  reg  [2:0]  strobe_sync_reg;
  reg  [1:0]  rs_sync_reg;
  reg  [1:0]  rw_sync_reg;
  reg  [7:0]  d_sync1_reg;
  reg  [7:0]  d_sync2_reg;
  reg         nibble_wait_reg;
  reg  [3:0]  nibble_hi_reg;
  reg  [31:0] blink_cnt_reg;
  reg  [7:0]  clr_idx_reg;
  wire        strobe_rise;
  wire        rs;
  wire        rw;
  wire [7:0]  bus_byte;
  wire        byte_ready;
  integer     k;

  function [6:0] step7;
    input [6:0] v;
    input       up;
    begin
      step7 = up ? v + 7'h01 : v - 7'h01;
    end
  endfunction

  function [6:0] wrap_shift;
    input [6:0] v;
    input       up;
    begin
      if (up)
        wrap_shift = (v == `CDID_SH_MAX) ? 7'h00 : v + 7'h01;
      else
        wrap_shift = (v == 7'h00) ? `CDID_SH_MAX : v - 7'h01;
    end
  endfunction

  assign strobe_rise = strobe_sync_reg[1] & ~strobe_sync_reg[2];
  assign rs = rs_sync_reg[1];
  assign rw = rw_sync_reg[1];
  // Narrow bus pairs two strobes into one byte
  assign bus_byte = bus_width_select_o ? d_sync2_reg : {nibble_hi_reg, d_sync2_reg[7:4]}; // R24
  assign byte_ready = strobe_rise & (bus_width_select_o | nibble_wait_reg); // R24 R16

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strobe_sync_reg <= 3'h0;
      rs_sync_reg     <= 2'h0;
      rw_sync_reg     <= 2'h0;
      d_sync1_reg     <= 8'h00;
      d_sync2_reg     <= 8'h00;
    end else begin
      strobe_sync_reg <= {strobe_sync_reg[1:0], xfer_strobe_i};
      rs_sync_reg     <= {rs_sync_reg[0], register_select_i};
      rw_sync_reg     <= {rw_sync_reg[0], read_not_write_i};
      d_sync1_reg     <= data_i;
      d_sync2_reg     <= d_sync1_reg;
    end
  end

  // Blink timebase, half period on and half off
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      blink_cnt_reg <= 32'h0;
      blink_phase_o <= 1'b0;
    end else if (!blink_enable_o) begin
      blink_cnt_reg <= 32'h0; // R07
      blink_phase_o <= 1'b0;
    end else if (blink_cnt_reg == BLINK_HALF - 1) begin
      blink_cnt_reg <= 32'h0;
      blink_phase_o <= ~blink_phase_o; // R07
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end
  end

  // Space fill sweeps display RAM after reset or clear
  always @(posedge clk_sys_i) begin
    if (clear_busy_o)
      dd_mem[clr_idx_reg[6:0]] <= `CDID_SPACE_CODE; // R20 R22
    else if (byte_ready && rs && !rw && !glyph_select_o)
      dd_mem[address_counter_o] <= bus_byte; // R17
  end

  always @(posedge clk_sys_i) begin
    if (byte_ready && rs && !rw && glyph_select_o)
      cg_mem[address_counter_o[5:0]] <= bus_byte; // R17 R23
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clr_idx_reg            <= 8'h00;
      clear_busy_o           <= 1'b1; // R20
      nibble_wait_reg        <= 1'b0;
      nibble_hi_reg          <= 4'h0;
      data_o                 <= 8'h00;
      read_valid_o           <= 1'b0;
      address_counter_o      <= `CDID_ACC_RESET; // R20
      glyph_select_o         <= 1'b0;
      display_shift_o        <= 7'h00;
      increment_direction_o  <= 1'b1; // R21
      shift_enable_o         <= 1'b0;
      display_enable_o       <= 1'b0;
      cursor_enable_o        <= 1'b0;
      blink_enable_o         <= 1'b0;
      bus_width_select_o     <= 1'b1;
      two_lines_o            <= 1'b1;
      luminance_code_high_o  <= 1'b0;
      luminance_code_low_o   <= 1'b0;
    end else begin
      read_valid_o <= 1'b0;
      if (clear_busy_o) begin
        clr_idx_reg <= clr_idx_reg + 8'h01;
        if (clr_idx_reg == `CDID_DD_DEPTH - 1)
          clear_busy_o <= 1'b0;
      end
      if (strobe_rise && !bus_width_select_o && !nibble_wait_reg) begin
        nibble_wait_reg <= 1'b1; // R24
        nibble_hi_reg   <= d_sync2_reg[7:4];
      end else if (strobe_rise) begin
        nibble_wait_reg <= 1'b0;
      end
      if (byte_ready) begin
        if (!rs && rw) begin
          data_o       <= {1'b0, address_counter_o}; // R15
          read_valid_o <= 1'b1;
        end else if (rs && rw) begin
          // R19: host points the counter first
          data_o       <= glyph_select_o ? cg_mem[address_counter_o[5:0]]
                                         : dd_mem[address_counter_o]; // R18
          read_valid_o <= 1'b1;
          address_counter_o <= step7(address_counter_o, increment_direction_o)
                               & (glyph_select_o ? 7'h3F : 7'h7F); // R02 R03 R04
        end else if (rs) begin
          address_counter_o <= step7(address_counter_o, increment_direction_o)
                               & (glyph_select_o ? 7'h3F : 7'h7F); // R02 R03
          if (shift_enable_o && !glyph_select_o)
            display_shift_o <= wrap_shift(display_shift_o, increment_direction_o); // R02 R03 R04
        end else begin
          // Highest set bit selects the command
          casez (bus_byte) // R25
            8'b1???????: begin
              address_counter_o <= bus_byte[6:0]; // R14
              glyph_select_o    <= 1'b0;
            end
            8'b01??????: begin
              address_counter_o <= {1'b0, bus_byte[5:0]}; // R13
              glyph_select_o    <= 1'b1;
            end
            8'b001?????: begin
              bus_width_select_o    <= bus_byte[4]; // R10
              two_lines_o           <= bus_byte[3]; // R11
              luminance_code_high_o <= bus_byte[1]; // R12
              luminance_code_low_o  <= bus_byte[0];
            end
            8'b0001????: begin
              address_counter_o <= step7(address_counter_o, bus_byte[2]); // R08
              glyph_select_o    <= 1'b0; // R09
              if (bus_byte[3])
                display_shift_o <= wrap_shift(display_shift_o, bus_byte[2]); // R08
            end
            8'b00001???: begin
              display_enable_o <= bus_byte[2]; // R05
              cursor_enable_o  <= bus_byte[1]; // R06
              blink_enable_o   <= bus_byte[0]; // R07
            end
            8'b000001??: begin
              increment_direction_o <= bus_byte[1]; // R04
              shift_enable_o        <= bus_byte[0];
            end
            8'b0000001?: begin
              address_counter_o <= 7'h00; // R01
              glyph_select_o    <= 1'b0;
              display_shift_o   <= 7'h00;
            end
            8'b00000001: begin
              address_counter_o     <= 7'h00; // R22
              glyph_select_o        <= 1'b0;
              display_shift_o       <= 7'h00;
              increment_direction_o <= 1'b1;
              clr_idx_reg           <= 8'h00;
              clear_busy_o          <= 1'b1;
            end
            default: begin
              glyph_select_o <= glyph_select_o;
            end
          endcase
        end
      end
    end
  end
endmodule // cdid_decoder
`default_nettype wire

// ===== hw/cdid_defines.vh
// What this block does
// R01: Home sets address zero, cancels shift
// R02: Decrement mode steps down, shifts right
// R03: Increment mode steps up, shifts left
// R04: Shift only on display writes, gated
// R05: Display enable bit blanks or shows
// R06: Cursor lights eighth row at address
// R07: Blink alternates cursor cell near 1Hz
// R08: Shift command steps counter, optionally screen
// R09: Shift command selects display RAM
// R10: Function set bit four picks width
// R11: Function set bit three picks lines
// R12: Low bits pick brightness level
// R13: Glyph address command loads six bits
// R14: Display address command loads seven bits
// R15: Counter read returns counter, busy zero
// R16: Every transfer accepted, never busy; code drops display RAM writes while the space fill runs
// R17: Data write stores, then steps counter; code skips the display RAM store during space fill but still steps
// R18: Data read returns byte, then steps
// R19: Host sets address before data read
// R20: Reset fills spaces, address zero
// R21: Reset settings as documented defaults
// R22: Clear fills spaces, forces increment
// R23: Glyph RAM holds sixty-four bytes
// R24: Narrow bus takes two nibbles, high first
// R25: Command picked by highest set bit
`ifndef CDID_DEFINES_VH
`define CDID_DEFINES_VH
`define CDID_SPACE_CODE     8'h20
`define CDID_DD_DEPTH       128
`define CDID_CG_DEPTH       64
`define CDID_ACC_RESET      7'h00
`define CDID_CLK_HZ         100000000
`define CDID_BLINK_HZ       1
`define CDID_BLINK_HALF     (`CDID_CLK_HZ / `CDID_BLINK_HZ / 2)
`define CDID_SH_MAX         7'h27
`endif

// ===== tb/cdid_host.sv
`default_nettype none
module cdid_host (
  input  wire logic       clk_sys_i,
  output var  logic       strobe_o,
  output var  logic       sel_o,
  output var  logic       rnw_o,
  output var  logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic narrow_reg = 1'h0;
  initial {strobe_o, sel_o, rnw_o, data_o} = 11'h000;
  // Back to back transfers; narrow mode sends high nibble first
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d);
    for (int n = 0; n <= int'(narrow_reg); n++) begin
      @(posedge clk_sys_i);
      {sel_o, rnw_o, strobe_o} <= {rs, rw, 1'h1};
      data_o <= (n == 0) ? d : {d[3:0], 4'hA};
      repeat (3) @(posedge clk_sys_i);
      strobe_o <= 1'h0;
      repeat (3) @(posedge clk_sys_i);
      data_o <= ~data_o;
    end
  endtask
endmodule // cdid_host
`default_nettype wire

// ===== tb/cdid_properties.sv
`default_nettype none
module cdid_properties #(
  parameter int BLINK_HALF = 10
) (
  input wire logic       clk_sys_i,
  input wire logic       rst_b_i,
  input wire logic       xfer_strobe_i,
  input wire logic       register_select_i,
  input wire logic [7:0] data_o,
  input wire logic       read_valid_o,
  input wire logic [6:0] address_counter_o,
  input wire logic       glyph_select_o,
  input wire logic       increment_direction_o,
  input wire logic       blink_enable_o,
  input wire logic       blink_phase_o,
  input wire logic [6:0] display_shift_o,
  input wire logic       clear_busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BW = BLINK_HALF + 2;
  logic [3:0] quiet_reg;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // Cycles since the last strobe rise, saturating
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
    if (!rst_b_i) quiet_reg <= 4'h0;
    else if ($rose(xfer_strobe_i)) quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hF) quiet_reg <= quiet_reg + 4'h1;
  a_valid_pulse: assert property (read_valid_o |=> !read_valid_o)
    else $error("read pulse too long");
  a_busy_zero: assert property (read_valid_o && !register_select_i |->
    data_o == {1'h0, address_counter_o}) else $error("counter read wrong");
  a_read_caused: assert property (read_valid_o |-> quiet_reg <= 4'h7)
    else $error("read without transfer");
  a_idle_stable: assert property (quiet_reg >= 4'h9 |->
    $stable({address_counter_o, glyph_select_o, increment_direction_o, display_shift_o}))
    else $error("state moved while idle");
  a_blink_off: assert property (!blink_enable_o |-> !blink_phase_o)
    else $error("blink phase while off");
  a_blink_toggle: assert property (blink_enable_o && !blink_phase_o |->
    ##[1:BW] (blink_phase_o || !blink_enable_o)) else $error("blink stuck");
  a_glyph_range: assert property (glyph_select_o |-> !address_counter_o[6])
    else $error("glyph address too wide");
  a_clear_entry: assert property ($rose(clear_busy_o) |-> ##[0:1]
    (increment_direction_o && display_shift_o == 7'h00)) else $error("clear state wrong");
  c_read: cover property (read_valid_o && !register_select_i);
  c_blink: cover property ($rose(blink_phase_o));
  c_clear: cover property ($rose(clear_busy_o));
endmodule // cdid_properties
bind cdid_decoder cdid_properties #(.BLINK_HALF(BLINK_HALF)) u_cdid_properties (.*);
`default_nettype wire

// ===== tb/char_display_instruction_decoder_tb.sv
`default_nettype none
module char_display_instruction_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys_i = 1'h0;
  logic       rst_b_i = 1'h0;
  logic       xfer_strobe_i, register_select_i, read_not_write_i, read_valid_o, clear_busy_o;
  logic [7:0] data_i, data_o, a, v;
  logic [6:0] address_counter_o, display_shift_o;
  logic       glyph_select_o, increment_direction_o, shift_enable_o, display_enable_o;
  logic       cursor_enable_o, blink_enable_o, blink_phase_o, bus_width_select_o;
  logic       two_lines_o, luminance_code_high_o, luminance_code_low_o;
  int         n_mismatch = 0, n_compared = 0, cyc = 0;
  initial forever #5 clk_sys_i = ~clk_sys_i;
  cdid_decoder #(.BLINK_HALF(10)) u_cdid_decoder (.*);
  cdid_host u_cdid_host (.clk_sys_i(clk_sys_i), .strobe_o(xfer_strobe_i),
    .sel_o(register_select_i), .rnw_o(read_not_write_i), .data_o(data_i));
  function automatic logic [7:0] step(input logic [7:0] x);
    return {1'h0, 7'(x + 8'h01)};
  endfunction
  function automatic logic [15:0] st();
    return {glyph_select_o, address_counter_o, 1'h0, display_shift_o};
  endfunction
  function automatic logic [7:0] cfg();
    return {shift_enable_o, display_enable_o, cursor_enable_o, blink_enable_o,
      bus_width_select_o, two_lines_o, luminance_code_high_o, luminance_code_low_o};
  endfunction
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] d); u_cdid_host.xfer(1'h0, 1'h0, d); endtask
  task automatic wr(input logic [7:0] d); u_cdid_host.xfer(1'h1, 1'h0, d); endtask
  task automatic rd(input logic rs, input logic [7:0] e);
    u_cdid_host.xfer(rs, 1'h1, 8'h00);
    chk(data_o, e);
  endtask
  task automatic fill_wait;
    for (int i = 0; i < 300 && clear_busy_o !== 1'h0; i++) @(posedge clk_sys_i);
  endtask
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      test_done;
    end
  end
  initial begin
    a = 8'($urandom(33120));
    repeat (5) @(posedge clk_sys_i);
    rst_b_i <= 1'h1;
    @(posedge clk_sys_i);
    chk({increment_direction_o, cfg()}, 16'h010C);
    chk(st(), 16'h0000);
    fill_wait;
    repeat (8) begin
      a = 8'($urandom % 64);
      v = 8'($urandom);
      cmd(8'hC0 | a);
      rd(1'h1, 8'h20);
      cmd(8'h80 | a);
      wr(v);
      chk(st(), {step(a), 8'h00});
      cmd(8'h80 | a);
      rd(1'h1, v);
    end
    cmd(8'h05);
    cmd(8'h80 | a);
    wr(8'h41);
    chk(st(), {1'h0, 7'(a - 8'h01), 8'h27});
    cmd(8'h80 | a);
    rd(1'h1, 8'h41);
    chk(st(), {1'h0, 7'(a - 8'h01), 8'h27});
    cmd(8'h07);
    cmd(8'h7F);
    wr(8'h5A);
    chk(st(), 16'h8027);
    cmd(8'h80);
    wr(8'h42);
    chk(st(), 16'h0100);
    cmd(8'h45);
    cmd(8'h14);
    chk(st(), 16'h0600);
    cmd(8'h10);
    chk(st(), 16'h0500);
    cmd(8'h1C);
    chk(st(), 16'h0601);
    rd(1'h0, 8'h06);
    cmd(8'h03);
    chk(st(), 16'h0000);
    for (int i = 0; i < 8; i++) begin
      cmd(8'h08 | 8'(i));
      chk(cfg() & 8'h70, {9'h000, 3'(i), 4'h0});
    end
    for (int i = 0; i < 8; i++) begin
      cmd({4'h3, i[2], 1'h1, i[1:0]});
      chk(cfg() & 8'h0F, {12'h000, 1'h1, 3'(i)});
    end
    cmd(8'h28);
    chk(cfg() & 8'h0F, 16'h0004);
    u_cdid_host.narrow_reg = 1'h1;
    cmd(8'h85);
    wr(8'hC3);
    cmd(8'h3C);
    u_cdid_host.narrow_reg = 1'h0;
    cmd(8'h85);
    rd(1'h1, 8'hC3);
    cmd(8'h04);
    cmd(8'h01);
    fill_wait;
    chk({increment_direction_o, st()}, 17'h10000);
    cmd(8'h80 | a);
    rd(1'h1, 8'h20);
    cmd(8'h7F);
    rd(1'h1, 8'h5A);
    test_done;
  end
endmodule // char_display_instruction_decoder_tb
`default_nettype wire
